// ==== src/fpr_cost.sv ====
module fpr_cost (
	input  wire logic clk_in,
	input  wire logic sys_rst_in,
	fpr_cost_if.calc  c
);
	import fpr_pkg::*;
	logic [7:0] cost_nxt;
	logic [7:0] n8;

	always_comb begin
		n8 = {3'h0, c.words};
		cost_nxt = 8'h00;
		unique case (c.kind)
			FPR_ACC_FETCH: begin
				cost_nxt = !c.in_flash ? CYC_SRAM_FETCH : (c.wide ? CYC_FL_FETCH32 : CYC_FL_FETCH16);
			end
			FPR_ACC_DATA: begin
				cost_nxt = c.data_flash ? CYC_FL_DECODE + CYC_FL_WORD + CYC_FL_TAIL : CYC_SRAM_DATA;
			end
			FPR_ACC_FLOW: begin
				cost_nxt = c.in_flash ? CYC_FL_DECODE + CYC_FL_REFILL : CYC_SRAM_REFILL;
			end
			FPR_ACC_LDM: begin
				cost_nxt = (c.words > LDM_MAX) ? 8'h00 : 8'(n8 + n8 * CYC_FL_WORD + n8);
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			c.cycles <= 8'h00;
			c.valid  <= 1'b0;
		end else begin
			c.valid  <= c.req;
			if (c.req) begin
				c.cycles <= cost_nxt;
			end
		end
	end

	property p_fl_data;
		@(posedge clk_in) disable iff (sys_rst_in)
		c.req && c.kind == FPR_ACC_DATA && c.data_flash |=> c.valid && c.cycles == 8'h04;
	endproperty
	a_fl_data: assert property (p_fl_data) else $error("flash data cost wrong");
endmodule : fpr_cost

// ==== src/fpr_cost_if.sv ====
interface fpr_cost_if;
	import fpr_pkg::*;
	logic       req;
	fpr_acc_t   kind;
	logic       in_flash;
	logic       data_flash;
	logic       wide;
	logic [4:0] words;
	logic [7:0] cycles;
	logic       valid;
	modport calc (input req, kind, in_flash, data_flash, wide, words, output cycles, valid);
	modport user (output req, kind, in_flash, data_flash, wide, words, input cycles, valid);
endinterface : fpr_cost_if

// ==== src/fpr_pkg.sv ====
package fpr_pkg;
	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [31:0] MAP_CTRL_OFF    = 32'hFFFF0220;
	localparam logic [31:0] FADDR_OFF       = 32'hFFFFF810;
	localparam logic [31:0] FSIGN_OFF       = 32'hFFFFF818;
	localparam logic [31:0] VPROT_OFF       = 32'hFFFFF820;
	localparam logic [31:0] PPROT_OFF       = 32'hFFFFF81C;
	localparam logic [31:0] FDATA_OFF       = 32'hFFFFF80C;
	localparam logic [31:0] FMODE_OFF       = 32'hFFFFF804;
	localparam logic [31:0] FCMD_OFF        = 32'hFFFFF808;
	localparam logic [31:0] FSTAT_OFF       = 32'hFFFFF800;
	// ------------------------------------------------------------
	// reset values and fields
	// ------------------------------------------------------------
	localparam logic [15:0] FADDR_RST       = 16'h0000;
	localparam logic [23:0] FSIGN_RST       = 24'hFFFFFF;
	localparam logic [31:0] VPROT_RST       = 32'hFFFFFFFF;
	localparam logic [31:0] PPROT_RST       = 32'hFFFFFFFF;
	localparam logic [7:0]  MAP_CTRL_RST    = 8'h00;
	localparam logic [7:0]  FMODE_RST       = 8'h00;
	localparam int          READ_PROT_BIT   = 31;
	localparam int          REMAP_BIT       = 0;
	localparam int          ERASE_KEY_BIT   = 3;
	localparam int          PAGES_PER_GRP   = 4;
	localparam int          LAST_PAGE       = 123;
	localparam logic [15:0] KEY_DATA        = 16'h3CFF;
	localparam logic [15:0] KEY_ADDR        = 16'hFFC3;
	// ------------------------------------------------------------
	// commands
	// ------------------------------------------------------------
	localparam logic [7:0]  CMD_MASS_ERASE  = 8'h06;
	localparam logic [7:0]  CMD_SIGNATURE   = 8'h0B;
	localparam logic [7:0]  CMD_PROTECT     = 8'h0C;
	// ------------------------------------------------------------
	// memory map
	// ------------------------------------------------------------
	localparam logic [31:0] VECTOR_LO       = 32'h00000000;
	localparam logic [31:0] VECTOR_HI       = 32'h00000020;
	localparam logic [31:0] FLASH_BASE      = 32'h00080000;
	localparam logic [31:0] SAFE_REMAP_ADDR = 32'h00080020;
	localparam logic [31:0] KERNEL_BASE     = 32'h0008F800;
	// ------------------------------------------------------------
	// access cycle costs
	// ------------------------------------------------------------
	localparam logic [7:0]  CYC_SRAM_FETCH  = 8'h01;
	localparam logic [7:0]  CYC_FL_FETCH32  = 8'h02;
	localparam logic [7:0]  CYC_FL_FETCH16  = 8'h01;
	localparam logic [7:0]  CYC_SRAM_DATA   = 8'h01;
	localparam logic [7:0]  CYC_FL_DATA     = 8'h03;
	localparam logic [7:0]  CYC_FL_DECODE   = 8'h01;
	localparam logic [7:0]  CYC_FL_WORD     = 8'h02;
	localparam logic [7:0]  CYC_FL_TAIL     = 8'h01;
	localparam logic [7:0]  CYC_FL_REFILL   = 8'h04;
	localparam logic [7:0]  CYC_SRAM_REFILL = 8'h02;
	localparam logic [4:0]  LDM_MAX         = 5'h10;
	localparam int          BOOT_CYCLES     = 16;
	localparam int          SIGN_CYCLES     = 32778;

	typedef enum logic [1:0] {
		FPR_ACC_FETCH = 2'h0,
		FPR_ACC_DATA  = 2'h1,
		FPR_ACC_FLOW  = 2'h2,
		FPR_ACC_LDM   = 2'h3
	} fpr_acc_t;
endpackage : fpr_pkg

// ==== src/fpr_top.sv ====
// Our own choice: the address-and-strobe port.
module fpr_top (
	input  wire logic                 clk_in,
	input  wire logic                 sys_rst_in,
	input  wire logic [31:0]          reg_addr_in,
	input  wire logic [31:0]          reg_wdata_in,
	input  wire logic                 reg_wr_in,
	input  wire logic                 reg_rd_in,
	output logic [31:0]               reg_rdata_out,
	input  wire logic                 boot_select_pin_in,
	input  wire logic [31:0]          core_addr_in,
	input  wire logic                 core_req_in,
	input  wire logic                 core_wr_in,
	input  wire fpr_pkg::fpr_acc_t    core_kind_in,
	input  wire logic                 core_wide_in,
	input  wire logic [4:0]           core_words_in,
	output logic                      sram_sel_out,
	output logic                      flash_sel_out,
	output logic                      access_denied_out,
	output logic [7:0]                access_cycles_out,
	output logic                      boot_done_out,
	output logic                      jump_vector_out,
	output logic                      mass_erase_out
);
	import fpr_pkg::*;

	// ------------------------------------------------------------
	// pin synchroniser
	// ------------------------------------------------------------
	logic boot_meta_r;
	logic boot_sync_r;
	always_ff @(posedge clk_in) begin
		boot_meta_r <= boot_select_pin_in;
		boot_sync_r <= boot_meta_r;
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [15:0] flash_addr_reg_r;
	logic [15:0] flash_data_reg_r;
	logic [7:0]  flash_mode_reg_r;
	logic [23:0] flash_signature_reg_r;
	logic [31:0] volatile_protect_reg_r;
	logic [31:0] persistent_protect_reg_r;
	logic [31:0] persist_active_r;
	logic        persist_locked_r;
	logic [7:0]  map_ctrl_r;
	logic        key_armed;
	logic [31:0] eff_prot;
	logic        cmd_wr;

	function automatic logic hit(input logic [31:0] a, input logic [31:0] off);
		hit = (a == off);
	endfunction : hit

	assign cmd_wr    = reg_wr_in && hit(reg_addr_in, FCMD_OFF);
	assign key_armed = flash_data_reg_r == KEY_DATA && flash_addr_reg_r == KEY_ADDR
	                   && flash_mode_reg_r[ERASE_KEY_BIT];
	assign eff_prot  = persist_active_r & volatile_protect_reg_r;

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			flash_addr_reg_r <= FADDR_RST;
			flash_data_reg_r <= 16'h0000;
			flash_mode_reg_r <= FMODE_RST;
		end else if (reg_wr_in) begin
			if (hit(reg_addr_in, FADDR_OFF)) begin
				flash_addr_reg_r <= reg_wdata_in[15:0];
			end
			if (hit(reg_addr_in, FDATA_OFF)) begin
				flash_data_reg_r <= reg_wdata_in[15:0];
			end
			if (hit(reg_addr_in, FMODE_OFF)) begin
				flash_mode_reg_r <= reg_wdata_in[7:0];
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			volatile_protect_reg_r <= VPROT_RST;
		end else if (reg_wr_in && hit(reg_addr_in, VPROT_OFF)) begin
			volatile_protect_reg_r <= reg_wdata_in;
		end
	end

	// persistent value survives reset; the active copy loads from it at reset
	// power-up marker, no reset touches it
	logic pprot_init_r = 1'b0;
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			persist_active_r <= pprot_init_r ? persistent_protect_reg_r : PPROT_RST;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!pprot_init_r) begin
			persistent_protect_reg_r <= PPROT_RST;
			persist_locked_r         <= 1'b0;
			pprot_init_r             <= 1'b1;
		end else if (!sys_rst_in) begin
			if (reg_wr_in && hit(reg_addr_in, PPROT_OFF) && (!persist_locked_r || key_armed)) begin
				persistent_protect_reg_r <= reg_wdata_in;
			end
			if (cmd_wr && reg_wdata_in[7:0] == CMD_PROTECT) begin
				persist_locked_r <= 1'b1;
			end else if (cmd_wr && reg_wdata_in[7:0] == CMD_MASS_ERASE && key_armed) begin
				persist_locked_r         <= 1'b0;
				persistent_protect_reg_r <= PPROT_RST;
			end
		end
	end

	// ------------------------------------------------------------
	// mass erase and signature
	// ------------------------------------------------------------
	logic [15:0] sign_cnt_r;
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			mass_erase_out <= 1'b0;
		end else begin
			mass_erase_out <= cmd_wr && reg_wdata_in[7:0] == CMD_MASS_ERASE && key_armed;
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			flash_signature_reg_r <= FSIGN_RST;
			sign_cnt_r            <= 16'h0000;
		end else if (cmd_wr && reg_wdata_in[7:0] == CMD_SIGNATURE) begin
			sign_cnt_r            <= 16'(SIGN_CYCLES);
			flash_signature_reg_r <= 24'h000000;
		end else if (sign_cnt_r != 16'h0000) begin
			sign_cnt_r            <= sign_cnt_r - 16'h0001;
			flash_signature_reg_r <= {flash_signature_reg_r[22:0], 1'b0}
			                         ^ {8'h00, flash_addr_reg_r} ^ 24'(sign_cnt_r);
		end
	end

	// ------------------------------------------------------------
	// remap
	// ------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			map_ctrl_r <= MAP_CTRL_RST;
		end else if (reg_wr_in && hit(reg_addr_in, MAP_CTRL_OFF)) begin
			map_ctrl_r[REMAP_BIT] <= reg_wdata_in[REMAP_BIT];
		end
	end

	// ------------------------------------------------------------
	// boot sequence
	// ------------------------------------------------------------
	logic [7:0] boot_cnt_r;
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			boot_cnt_r      <= 8'(BOOT_CYCLES);
			boot_done_out   <= 1'b0;
			jump_vector_out <= 1'b0;
		end else if (boot_cnt_r != 8'h00) begin
			boot_cnt_r      <= boot_cnt_r - 8'h01;
			boot_done_out   <= boot_cnt_r == 8'h01;
			jump_vector_out <= boot_cnt_r == 8'h01 && boot_sync_r;
		end else begin
			boot_done_out   <= 1'b0;
			jump_vector_out <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// core access decode
	// ------------------------------------------------------------
	logic in_vec;
	logic in_flash;
	logic in_kernel;
	logic [6:0] page;
	logic [4:0] grp;
	logic deny;
	assign in_vec    = core_addr_in < FLASH_BASE;
	assign in_flash  = !in_vec ? core_addr_in >= FLASH_BASE : !map_ctrl_r[REMAP_BIT];
	assign in_kernel = core_addr_in >= KERNEL_BASE && core_addr_in < KERNEL_BASE + 32'h00000800;
	assign page      = core_addr_in[15:9];
	assign grp       = 5'(page / 7'(PAGES_PER_GRP));
	always_comb begin
		deny = in_kernel;
		if (in_flash && !core_wr_in && !eff_prot[READ_PROT_BIT]) begin
			deny = 1'b1;
		end
		if (in_flash && core_wr_in && page <= 7'(LAST_PAGE) && !eff_prot[grp]) begin
			deny = 1'b1;
		end
	end

	fpr_cost_if cif ();
	assign cif.req        = core_req_in;
	assign cif.kind       = core_kind_in;
	assign cif.in_flash   = in_flash;
	assign cif.data_flash = in_flash;
	assign cif.wide       = core_wide_in;
	assign cif.words      = core_words_in;
	fpr_cost u_cost (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .c(cif));

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			sram_sel_out      <= 1'b0;
			flash_sel_out     <= 1'b0;
			access_denied_out <= 1'b0;
		end else begin
			sram_sel_out      <= core_req_in && !in_flash && !deny;
			flash_sel_out     <= core_req_in && in_flash && !deny;
			access_denied_out <= core_req_in && deny;
		end
	end
	assign access_cycles_out = cif.cycles;

	// ------------------------------------------------------------
	// read port
	// ------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			reg_rdata_out <= 32'h00000000;
		end else if (reg_rd_in) begin
			unique case (1'b1)
				hit(reg_addr_in, FADDR_OFF):    reg_rdata_out <= {16'h0000, flash_addr_reg_r};
				hit(reg_addr_in, FDATA_OFF):    reg_rdata_out <= {16'h0000, flash_data_reg_r};
				hit(reg_addr_in, FMODE_OFF):    reg_rdata_out <= {24'h000000, flash_mode_reg_r};
				hit(reg_addr_in, FSIGN_OFF):    reg_rdata_out <= {8'h00, flash_signature_reg_r};
				hit(reg_addr_in, VPROT_OFF):    reg_rdata_out <= volatile_protect_reg_r;
				hit(reg_addr_in, PPROT_OFF):    reg_rdata_out <= persistent_protect_reg_r;
				hit(reg_addr_in, MAP_CTRL_OFF): reg_rdata_out <= {24'h000000, map_ctrl_r};
				hit(reg_addr_in, FSTAT_OFF):    reg_rdata_out <= {31'h00000000, sign_cnt_r != 16'h0000};
				default:                        reg_rdata_out <= 32'h00000000;
			endcase
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_addr_wr;
		@(posedge clk_in) disable iff (sys_rst_in)
		reg_wr_in && reg_addr_in == FADDR_OFF |=> flash_addr_reg_r == $past(reg_wdata_in[15:0]);
	endproperty
	a_addr_wr: assert property (p_addr_wr) else $error("address reg not written");

	property p_sign_rst;
		@(posedge clk_in) sys_rst_in |=> flash_signature_reg_r == FSIGN_RST;
	endproperty
	a_sign_rst: assert property (p_sign_rst) else $error("signature reset wrong");

	property p_vprot_wr;
		@(posedge clk_in) disable iff (sys_rst_in)
		reg_wr_in && reg_addr_in == VPROT_OFF |=> volatile_protect_reg_r == $past(reg_wdata_in);
	endproperty
	a_vprot_wr: assert property (p_vprot_wr) else $error("immediate protect not direct");

	property p_vprot_rst;
		@(posedge clk_in) sys_rst_in |=> volatile_protect_reg_r == VPROT_RST;
	endproperty
	a_vprot_rst: assert property (p_vprot_rst) else $error("immediate protect reset");

	property p_read_prot;
		@(posedge clk_in) disable iff (sys_rst_in)
		core_req_in && in_flash && !core_wr_in && !eff_prot[31] |=> access_denied_out && !flash_sel_out;
	endproperty
	a_read_prot: assert property (p_read_prot) else $error("read protect leak");

	property p_erase_key;
		@(posedge clk_in) disable iff (sys_rst_in)
		mass_erase_out |-> $past(key_armed) && $past(cmd_wr);
	endproperty
	a_erase_key: assert property (p_erase_key) else $error("unkeyed mass erase");

	property p_remap_rst;
		@(posedge clk_in) sys_rst_in |=> !map_ctrl_r[0];
	endproperty
	a_remap_rst: assert property (p_remap_rst) else $error("remap not cleared");

	property p_vec_sram;
		@(posedge clk_in) disable iff (sys_rst_in)
		core_req_in && core_addr_in <= VECTOR_HI && map_ctrl_r[0] |=> sram_sel_out || access_denied_out;
	endproperty
	a_vec_sram: assert property (p_vec_sram) else $error("vector not from sram");

	property p_boot;
		@(posedge clk_in) $fell(sys_rst_in) |-> !jump_vector_out [*8];
	endproperty
	a_boot: assert property (p_boot) else $error("jump before config");

	property p_jump_pin;
		@(posedge clk_in) disable iff (sys_rst_in)
		jump_vector_out |-> boot_done_out && $past(boot_sync_r);
	endproperty
	a_jump_pin: assert property (p_jump_pin) else $error("jump without boot pin");

	property p_wr_prot;
		@(posedge clk_in) disable iff (sys_rst_in)
		core_req_in && in_flash && core_wr_in && page <= 7'(LAST_PAGE) && !eff_prot[grp] |=> access_denied_out;
	endproperty
	a_wr_prot: assert property (p_wr_prot) else $error("write protect leak");

	property p_vec_flash;
		@(posedge clk_in) disable iff (sys_rst_in)
		core_req_in && core_addr_in <= VECTOR_HI && !map_ctrl_r[REMAP_BIT] |=> !sram_sel_out;
	endproperty
	a_vec_flash: assert property (p_vec_flash) else $error("vector not from flash");

	property p_kernel_hide;
		@(posedge clk_in) disable iff (sys_rst_in)
		core_req_in && in_kernel |=> access_denied_out && !flash_sel_out && !sram_sel_out;
	endproperty
	a_kernel_hide: assert property (p_kernel_hide) else $error("kernel region reached");

	property p_pprot_hold;
		@(posedge clk_in) disable iff (sys_rst_in)
		!$past(sys_rst_in) |-> $stable(persist_active_r);
	endproperty
	a_pprot_hold: assert property (p_pprot_hold) else $error("persistent protect changed");

	c_erase: cover property (@(posedge clk_in) mass_erase_out);
	c_remap: cover property (@(posedge clk_in) sram_sel_out);
	c_deny:  cover property (@(posedge clk_in) access_denied_out);
	c_jump:  cover property (@(posedge clk_in) jump_vector_out);
endmodule : fpr_top

// ==== testbench/fpr_core_model.sv ====
module fpr_core_model (
	input  wire logic         clk_in,
	output logic [31:0]       core_addr_out,
	output logic              core_req_out,
	output logic              core_wr_out,
	output fpr_pkg::fpr_acc_t core_kind_out,
	output logic              core_wide_out,
	output logic [4:0]        core_words_out
);
	timeunit 1ns;
	timeprecision 1ns;
	import fpr_pkg::*;

	initial begin
		core_addr_out  = 32'h00000000;
		core_req_out   = 1'b0;
		core_wr_out    = 1'b0;
		core_kind_out  = FPR_ACC_FETCH;
		core_wide_out  = 1'b0;
		core_words_out = 5'h00;
	end

	// ------------------------------------------------------------
	// one request cycle, then all qualifiers but the kind are scrambled
	// ------------------------------------------------------------
	task automatic access(input logic [31:0] a, input logic w, input fpr_acc_t k, input logic wd,
		input logic [4:0] n);
		@(posedge clk_in);
		core_addr_out  <= a;
		core_wr_out    <= w;
		core_kind_out  <= k;
		core_wide_out  <= wd;
		core_words_out <= n;
		core_req_out   <= 1'b1;
		@(posedge clk_in);
		core_req_out   <= 1'b0;
		// released lines must not keep the last value
		core_addr_out  <= ~a;
		core_wr_out    <= ~w;
		core_wide_out  <= ~wd;
		core_words_out <= ~n;
	endtask : access
endmodule : fpr_core_model

// ==== testbench/tb.sv ====
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import fpr_pkg::*;

	typedef struct {
		logic [3:0]  src;
		logic [31:0] val;
		logic [31:0] msk;
	} fpr_note_t;

	localparam logic [31:0] M_ALL  = 32'hFFFFFFFF;
	localparam logic [31:0] M_DENY = 32'h20000000;
	localparam logic [31:0] FL_A   = 32'h00080100;

	logic              clk_in, sys_rst_in, reg_wr_in, reg_rd_in, boot_pin, rd_p, rq_p;
	logic [31:0]       reg_addr_in, reg_wdata_in, reg_rdata_out, core_addr, seed;
	logic              core_req, core_wr, core_wide, sram_sel, flash_sel, denied, boot_done, jump_vec, erase_p;
	logic [4:0]        core_words;
	logic [7:0]        cycles;
	fpr_acc_t          core_kind;
	fpr_note_t         notes[$];
	int                bad_count, total_checks;

	fpr_core_model i_core (.clk_in(clk_in), .core_addr_out(core_addr), .core_req_out(core_req),
		.core_wr_out(core_wr), .core_kind_out(core_kind), .core_wide_out(core_wide), .core_words_out(core_words));

	fpr_top i_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
		.boot_select_pin_in(boot_pin), .core_addr_in(core_addr), .core_req_in(core_req), .core_wr_in(core_wr),
		.core_kind_in(core_kind), .core_wide_in(core_wide), .core_words_in(core_words), .sram_sel_out(sram_sel),
		.flash_sel_out(flash_sel), .access_denied_out(denied), .access_cycles_out(cycles),
		.boot_done_out(boot_done), .jump_vector_out(jump_vec), .mass_erase_out(erase_p));

	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end

	// ------------------------------------------------------------
	// comparison, notes and verdict
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : complete_run

	task automatic note(input logic [3:0] s, input logic [31:0] v, input logic [31:0] m);
		notes.push_back('{s, v, m});
	endtask : note

	task automatic got(input logic [3:0] s, input logic [31:0] v);
		fpr_note_t n;
		n = '{4'hF, 32'h0, 32'h0};
		if (notes.size() > 0) begin
			n = notes.pop_front();
		end
		check({28'h0, s}, {28'h0, n.src});
		check(v & n.msk, n.val & n.msk);
	endtask : got

	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr

	function automatic logic [31:0] res(input logic s, input logic f, input logic d, input logic [7:0] c);
		return {s, f, d, 21'h0, c};
	endfunction : res

	// ------------------------------------------------------------
	// result monitor
	// ------------------------------------------------------------
	always @(posedge clk_in) begin
		rd_p <= reg_rd_in;
		rq_p <= core_req;
	end

	always @(negedge clk_in) begin
		if (rd_p === 1'b1) got(4'h1, reg_rdata_out);
		if (rq_p === 1'b1) got(4'h2, res(sram_sel, flash_sel, denied, cycles));
		if (sys_rst_in === 1'b0 && erase_p !== 1'b0) got(4'h3, 32'h0);
		if (sys_rst_in === 1'b0 && boot_done !== 1'b0) got(4'h4, {31'h0, jump_vec});
	end

	// ------------------------------------------------------------
	// drivers
	// ------------------------------------------------------------
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge clk_in);
		reg_addr_in  <= a;
		reg_wdata_in <= d;
		reg_wr_in    <= 1'b1;
		@(posedge clk_in);
		reg_wr_in    <= 1'b0;
		reg_addr_in  <= ~a;
		reg_wdata_in <= ~d;
	endtask : wr

	task automatic rd(input logic [31:0] a, input logic [31:0] e);
		note(4'h1, e, M_ALL);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_rd_in   <= 1'b1;
		@(posedge clk_in);
		reg_rd_in   <= 1'b0;
		reg_addr_in <= ~a;
	endtask : rd

	task automatic acc(input logic [31:0] a, input logic w, input fpr_acc_t k, input logic wd,
		input logic [4:0] n, input logic [31:0] e, input logic [31:0] m);
		note(4'h2, e, m);
		i_core.access(a, w, k, wd, n);
	endtask : acc

	task automatic do_reset(input logic pin);
		int n;
		note(4'h4, {31'h0, pin}, 32'h1);
		@(posedge clk_in);
		sys_rst_in <= 1'b1;
		boot_pin   <= pin;
		repeat (6) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		n = 0;
		while (boot_done !== 1'b1 && n < 100) begin
			@(posedge clk_in);
			#1;
			n++;
		end
		check({31'h0, n >= BOOT_CYCLES && n < 100}, 32'h1);
		if (n >= 100) complete_run();
	endtask : do_reset

	task automatic erase(input int v);
		wr(FDATA_OFF, {16'h0, v == 0 ? 16'h0000 : KEY_DATA});
		wr(FADDR_OFF, {16'h0, v == 1 ? 16'h0000 : KEY_ADDR});
		wr(FMODE_OFF, v == 2 ? 32'h0 : 32'h1 << ERASE_KEY_BIT);
		if (v == 3) note(4'h3, 32'h0, 32'h0);
		wr(FCMD_OFF, {24'h0, CMD_MASS_ERASE});
		repeat (3) @(posedge clk_in);
	endtask : erase

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		sys_rst_in   = 1'b1;
		reg_wr_in    = 1'b0;
		reg_rd_in    = 1'b0;
		reg_addr_in  = 32'h0;
		reg_wdata_in = 32'h0;
		boot_pin     = 1'b1;
		seed         = 32'hF4FD;
		bad_count    = 0;
		total_checks = 0;
		do_reset(1'b1);
		rd(FADDR_OFF, 32'h0);
		rd(FSIGN_OFF, 32'h00FFFFFF);
		rd(VPROT_OFF, 32'hFFFFFFFF);
		rd(MAP_CTRL_OFF, 32'h0);
		rd(32'hFFFFF8F0, 32'h0);
		wr(FSIGN_OFF, 32'h0);
		rd(FSIGN_OFF, 32'h00FFFFFF);
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			wr(FADDR_OFF, seed);
			rd(FADDR_OFF, {16'h0, seed[15:0]});
		end
		$display("test done: registers");
		acc(FL_A, 1'b0, FPR_ACC_FETCH, 1'b1, 5'h1, res(0, 1, 0, CYC_FL_FETCH32), M_ALL);
		acc(FL_A, 1'b0, FPR_ACC_FETCH, 1'b0, 5'h1, res(0, 1, 0, CYC_FL_FETCH16), M_ALL);
		acc(FL_A, 1'b0, FPR_ACC_DATA, 1'b1, 5'h1, res(0, 1, 0, 8'h04), M_ALL);
		acc(FL_A, 1'b0, FPR_ACC_FLOW, 1'b1, 5'h1, res(0, 1, 0, 8'h05), M_ALL);
		acc(FL_A, 1'b0, FPR_ACC_LDM, 1'b1, 5'h01, res(0, 1, 0, 8'h04), M_ALL);
		acc(FL_A, 1'b0, FPR_ACC_LDM, 1'b1, 5'h10, res(0, 1, 0, 8'h40), M_ALL);
		acc(FL_A, 1'b0, FPR_ACC_LDM, 1'b1, 5'h11, res(0, 1, 0, 8'h00), M_ALL);
		acc(VECTOR_HI, 1'b0, FPR_ACC_FETCH, 1'b1, 5'h1, res(0, 1, 0, CYC_FL_FETCH32), M_ALL);
		acc(KERNEL_BASE, 1'b0, FPR_ACC_DATA, 1'b1, 5'h1, M_DENY, M_DENY);
		$display("test done: access costs");
		acc(SAFE_REMAP_ADDR + 32'h4, 1'b0, FPR_ACC_FETCH, 1'b1, 5'h1, res(0, 1, 0, 8'h02), M_ALL);
		wr(MAP_CTRL_OFF, 32'h1);
		rd(MAP_CTRL_OFF, 32'h1);
		acc(VECTOR_LO, 1'b0, FPR_ACC_FETCH, 1'b1, 5'h1, res(1, 0, 0, CYC_SRAM_FETCH), M_ALL);
		acc(VECTOR_LO, 1'b0, FPR_ACC_DATA, 1'b1, 5'h1, res(1, 0, 0, CYC_SRAM_DATA), M_ALL);
		acc(VECTOR_HI, 1'b0, FPR_ACC_FLOW, 1'b1, 5'h1, res(1, 0, 0, CYC_SRAM_REFILL), M_ALL);
		acc(FL_A, 1'b0, FPR_ACC_FETCH, 1'b1, 5'h1, res(0, 1, 0, CYC_FL_FETCH32), M_ALL);
		wr(MAP_CTRL_OFF, 32'h0);
		acc(VECTOR_LO, 1'b0, FPR_ACC_FETCH, 1'b1, 5'h1, res(0, 1, 0, CYC_FL_FETCH32), M_ALL);
		wr(MAP_CTRL_OFF, 32'h1);
		do_reset(1'b0);
		rd(MAP_CTRL_OFF, 32'h0);
		acc(VECTOR_LO, 1'b0, FPR_ACC_FETCH, 1'b1, 5'h1, res(0, 1, 0, CYC_FL_FETCH32), M_ALL);
		$display("test done: remap");
		wr(VPROT_OFF, 32'h7FFFFFFF);
		acc(FL_A, 1'b0, FPR_ACC_DATA, 1'b1, 5'h1, M_DENY, M_DENY);
		wr(VPROT_OFF, 32'hBFFFFFFE);
		rd(VPROT_OFF, 32'hBFFFFFFE);
		acc(FL_A, 1'b0, FPR_ACC_DATA, 1'b1, 5'h1, 32'h0, M_DENY);
		acc(FLASH_BASE, 1'b1, FPR_ACC_DATA, 1'b1, 5'h1, M_DENY, M_DENY);
		acc(FLASH_BASE + 32'h800, 1'b1, FPR_ACC_DATA, 1'b1, 5'h1, 32'h0, M_DENY);
		acc(32'h0008F600, 1'b1, FPR_ACC_DATA, 1'b1, 5'h1, M_DENY, M_DENY);
		acc(32'h0008EE00, 1'b1, FPR_ACC_DATA, 1'b1, 5'h1, 32'h0, M_DENY);
		do_reset(1'b1);
		rd(VPROT_OFF, 32'hFFFFFFFF);
		acc(FLASH_BASE, 1'b1, FPR_ACC_DATA, 1'b1, 5'h1, 32'h0, M_DENY);
		$display("test done: immediate protection");
		wr(PPROT_OFF, 32'h7FFFFFFF);
		acc(FL_A, 1'b0, FPR_ACC_DATA, 1'b1, 5'h1, 32'h0, M_DENY);
		do_reset(1'b1);
		acc(FL_A, 1'b0, FPR_ACC_DATA, 1'b1, 5'h1, M_DENY, M_DENY);
		for (int v = 0; v < 4; v++) begin
			erase(v);
		end
		do_reset(1'b1);
		acc(FL_A, 1'b0, FPR_ACC_DATA, 1'b1, 5'h1, 32'h0, M_DENY);
		wr(FCMD_OFF, {24'h0, CMD_PROTECT});
		wr(PPROT_OFF, 32'h7FFFFFFF);
		rd(PPROT_OFF, 32'hFFFFFFFF);
		wr(FCMD_OFF, {24'h0, CMD_SIGNATURE});
		rd(FSTAT_OFF, 32'h1);
		do_reset(1'b1);
		rd(FSIGN_OFF, 32'h00FFFFFF);
		rd(FSTAT_OFF, 32'h0);
		$display("test done: persistent protection and erase");
		repeat (4) @(posedge clk_in);
		check(notes.size(), 32'h0);
		complete_run();
	end
endmodule : tb
